// >>> include/nsr_decim_defs.vh
`ifndef NSR_DECIM_DEFS_VH
`define NSR_DECIM_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_REQ_A_TUNE     10'h078
`define IDX_REQ_B_TUNE     10'h079
`define IDX_REQ_EN_DEC_A_LO 10'h07a
`define IDX_DEC_A_HI       10'h07b
`define IDX_DEC_B          10'h07c
`define ADDR_REQ_A_TUNE    {`IDX_REQ_A_TUNE, 2'b00}
`define ADDR_REQ_B_TUNE    {`IDX_REQ_B_TUNE, 2'b00}
`define ADDR_REQ_EN_DEC_A_LO {`IDX_REQ_EN_DEC_A_LO, 2'b00}
`define ADDR_DEC_A_HI      {`IDX_DEC_A_HI, 2'b00}
`define ADDR_DEC_B         {`IDX_DEC_B, 2'b00}
`define CFG_RESET          8'h00

// Field positions
`define TUNE_MSB           6
`define NSR_RST_EN_BIT     7
`define DUAL_PP_BIT        7
`define DEC_A0_BIT         0
`define EN_A11_BIT         4
`define EN_A12_BIT         5
`define EN_B11_BIT         6
`define EN_B12_BIT         7

// Tuning word ranges
`define TUNE_11_SPLIT      21
`define TUNE_12_LO         42
`define TUNE_12_SPLIT      63

// Band centres as fractions of the sample rate, Q16
`define FC_22_BASE         7864
`define FC_22_STEP         852
`define FC_25_BASE         8192
`define FC_25_STEP         819
`define FC_29_BASE         9830
`define FC_29_STEP         1092
`define FC_QUARTER         16384
`define TWO_PI_Q12         25736
`define COEF_FRAC          14

// Channel modes
`define MODE_SINGLE        2'b00
`define MODE_DUAL          2'b01
`define MODE_OCTAL_CW      2'b10

`endif

// >>> logic/nsr_decim.v
// Contract
// [RULE1] Software matches tuning word range to mode
// [RULE2] Mismatched word and mode gives undefined output
// [RULE3] 11-bit words 0-20 22%, 21-41 25%
// [RULE4] 12-bit words 42-62 25%, 63-76 29%
// [RULE5] Disabled requantizer passes samples straight through
// [RULE6] Per-channel 11/12-bit enables at requant_enable_decim_a_low
// [RULE7] Tuning fields at requant_a_tuning_cfg and requant_b_tuning_cfg
// [RULE8] Reset enable clears requantizer on overload
// [RULE9] Dual post-processing enable bit at requant_b_tuning_cfg
// [RULE10] Decimation only single, dual, CW octal
// [RULE11] Thermometer stage fields at requant_enable_decim_a_low-decim_b_stage_cfg
// [RULE12] Single mode: B off, A up to 512x
// [RULE13] Dual mode: both chains, same rate
// [RULE14] Software clears A stage bit 0 for dual
// [RULE15] Dual mode maximum rate is 256x
// [RULE16] Requantize to 11/12 bits, noise out of band
// [RULE17] A serves first input, B the second
// [RULE18] Each set stage bit adds one halving stage
// [RULE19] Tuning word is the unsigned field value
`timescale 1ns/1ps
`include "nsr_decim_defs.vh"

module nsr_decim #(
    parameter DATA_W  = 16,
    parameter NSTAGE  = 9
) (
    // Clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // APB slave
    input  wire [11:0]       paddr,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // Converter core side
    input  wire [1:0]        chan_mode,
    input  wire [DATA_W-1:0] sample_a,
    input  wire [DATA_W-1:0] sample_b,
    input  wire              sample_valid,
    input  wire              overload,
    // Processed output
    output reg  [DATA_W-1:0] out_a,
    output reg               out_a_valid,
    output reg  [DATA_W-1:0] out_b,
    output reg               out_b_valid
);

    localparam W = DATA_W + 4;
    // Low bits dropped by the requantizer in each mode
    localparam integer DROP11_I = DATA_W - 11;
    localparam integer DROP12_I = DATA_W - 12;
    localparam [3:0]   DROP11   = DROP11_I[3:0];
    localparam [3:0]   DROP12   = DROP12_I[3:0];
    localparam signed [W-1:0] XMAX = {{(W-DATA_W+1){1'b0}}, {(DATA_W-1){1'b1}}};
    localparam signed [W-1:0] XMIN = ~XMAX;

    reg  [7:0]  tune_a_q;
    reg  [7:0]  tune_b_q;
    reg  [7:0]  en_dec_lo_q;
    reg  [7:0]  dec_a_hi_q;
    reg  [7:0]  dec_b_q;
    reg  [7:0]  rd_d;
    reg         hit;

    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready & pwrite;

    always @*
    begin
        hit  = 1'b1;
        rd_d = 8'h00;
        case (paddr)
            `ADDR_REQ_A_TUNE:      rd_d = tune_a_q;
            `ADDR_REQ_B_TUNE:      rd_d = tune_b_q;
            `ADDR_REQ_EN_DEC_A_LO: rd_d = en_dec_lo_q;
            `ADDR_DEC_A_HI:        rd_d = dec_a_hi_q;
            `ADDR_DEC_B:           rd_d = dec_b_q;
            default:               hit = 1'b0;
        endcase
    end

    // Answer is always one access cycle, so no wait state logic is needed
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup)
                prdata <= {24'h00_0000, rd_d};
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tune_a_q    <= `CFG_RESET;
            tune_b_q    <= `CFG_RESET;
            en_dec_lo_q <= `CFG_RESET;
            dec_a_hi_q  <= `CFG_RESET;
            dec_b_q     <= `CFG_RESET;
        end
        else if (wr_en)
        begin
            case (paddr)
                `ADDR_REQ_A_TUNE:      tune_a_q <= pwdata[7:0];    // [RULE7]
                `ADDR_REQ_B_TUNE:      tune_b_q <= pwdata[7:0];    // [RULE7]
                `ADDR_REQ_EN_DEC_A_LO: en_dec_lo_q <= pwdata[7:0]; // [RULE6]
                `ADDR_DEC_A_HI:        dec_a_hi_q <= pwdata[7:0];  // [RULE11]
                `ADDR_DEC_B:           dec_b_q <= pwdata[7:0];     // [RULE11]
                default:               tune_a_q <= tune_a_q;
            endcase
        end
    end

    // Mode decode
    wire mode_single = (chan_mode == `MODE_SINGLE);
    wire mode_dual   = (chan_mode == `MODE_DUAL);
    wire mode_cw     = (chan_mode == `MODE_OCTAL_CW);
    wire dual_pp     = tune_b_q[`DUAL_PP_BIT];
    wire dual_on     = mode_dual & dual_pp;                             // [RULE9]
    wire nsr_rst_en  = tune_a_q[`NSR_RST_EN_BIT];

    wire [8:0] dec_a_field = {dec_a_hi_q, en_dec_lo_q[`DEC_A0_BIT]};
    // Dual mode ignores A stage 0 and runs both chains on the common stages,
    // so a mismatched B field cannot leave the two outputs at different rates.
    wire [7:0] dual_stages = dec_a_field[8:1] & dec_b_q;                // [RULE13] [RULE14]
    wire [8:0] mask_a = (mode_single | mode_cw) ? dec_a_field :         // [RULE10] [RULE12]
                        dual_on ? {dual_stages, 1'b0} : 9'h000;         // [RULE15]
    wire [8:0] mask_b = dual_on ? {dual_stages, 1'b0} : 9'h000;         // [RULE12] [RULE13]

    wire nsr_ok_a = mode_single | dual_on;                              // [RULE17]
    wire nsr_ok_b = dual_on;                                            // [RULE17]

    // Feedback coefficient 2cos(2*pi*fc), Q14, from the tuning word.
    // Out-of-range words still yield a number; the result is then meaningless.
    function [17:0] coef;
        input [6:0] tune;
        input       mode12;
        integer     f;
        integer     t;
        integer     u;
        integer     u2;
        integer     c;
        begin
            if (!mode12)
            begin
                if (tune < `TUNE_11_SPLIT)                              // [RULE3]
                    f = `FC_22_BASE + `FC_22_STEP * tune;
                else
                    f = `FC_25_BASE + `FC_25_STEP * (tune - `TUNE_11_SPLIT);
            end
            else
            begin
                if (tune < `TUNE_12_SPLIT)                              // [RULE4]
                    f = `FC_25_BASE + `FC_25_STEP * (tune - `TUNE_12_LO);
                else
                    f = `FC_29_BASE + `FC_29_STEP * (tune - `TUNE_12_SPLIT);
            end
            t  = f - `FC_QUARTER;
            u  = (t * `TWO_PI_Q12) >>> 14;
            u2 = (u * u) >>> `COEF_FRAC;
            c  = -2 * u + ((u2 * u) >>> `COEF_FRAC) / 3;
            coef = c[17:0];
        end
    endfunction

    genvar ch;
    genvar s;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : g_ch
            wire [DATA_W-1:0] x_in  = (ch == 0) ? sample_a : sample_b;
            wire [6:0]        tune  = (ch == 0) ? tune_a_q[`TUNE_MSB:0]
                                                : tune_b_q[`TUNE_MSB:0];   // [RULE19]
            wire              en11  = (ch == 0) ? en_dec_lo_q[`EN_A11_BIT]
                                                : en_dec_lo_q[`EN_B11_BIT];
            wire              en12  = (ch == 0) ? en_dec_lo_q[`EN_A12_BIT]
                                                : en_dec_lo_q[`EN_B12_BIT];
            wire              ok    = (ch == 0) ? nsr_ok_a : nsr_ok_b;
            wire              on    = (en11 | en12) & ok;
            wire              m12   = en12 & ~en11;
            wire [8:0]        mask  = (ch == 0) ? mask_a : mask_b;
            // A always delivers samples; in other modes it passes them undecimated
            wire              ch_on = (ch == 0) ? 1'b1 : mode_dual;
            wire signed [17:0] c    = coef(tune, m12);                  // [RULE2]

            reg  signed [W-1:0]      e1_q;
            reg  signed [W-1:0]      e2_q;
            reg  signed [W+17:0]     prod;
            reg  signed [W-1:0]      v;
            reg  signed [W-1:0]      q;
            reg  signed [W-1:0]      lo_mask;
            reg  [W-1:0]             half;
            reg  signed [W+17:0]     fb;
            reg  [DATA_W-1:0]        y;
            wire [3:0]               drop = m12 ? DROP12 : DROP11;

            // Error feedback with NTF 1 - c*z^-1 + z^-2: the zero sits at the band centre
            always @*
            begin
                prod    = c * e1_q;
                fb      = prod >>> `COEF_FRAC;
                v       = $signed({{4{x_in[DATA_W-1]}}, x_in})
                          - $signed(fb[W-1:0]) + e2_q;
                lo_mask = ~({W{1'b1}} << drop);
                half    = {{(W-1){1'b0}}, 1'b1} << (drop - 4'd1);
                q       = (v + $signed(half)) & ~lo_mask;                // [RULE16]
                if (q > XMAX)
                    q = XMAX & ~lo_mask;
                else if (q < XMIN)
                    q = XMIN;
                y = on ? q[DATA_W-1:0] : x_in;                           // [RULE5]
            end

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    e1_q <= {W{1'b0}};
                    e2_q <= {W{1'b0}};
                end
                else if (!on || (nsr_rst_en && overload))               // [RULE8]
                begin
                    e1_q <= {W{1'b0}};
                    e2_q <= {W{1'b0}};
                end
                else if (sample_valid)
                begin
                    e1_q <= q - v;
                    e2_q <= e1_q;
                end
            end

            wire [DATA_W-1:0] dd [0:NSTAGE];
            wire              vv [0:NSTAGE];
            assign dd[0] = y;
            assign vv[0] = sample_valid & ch_on;

            // Each enabled stage averages a sample pair and halves the rate
            for (s = 0; s < NSTAGE; s = s + 1)
            begin : g_st
                reg  [DATA_W-1:0] hold_q;
                reg  [DATA_W-1:0] o_q;
                reg               ph_q;
                reg               ov_q;
                wire [DATA_W:0]   sum = {dd[s][DATA_W-1], dd[s]}
                                        + {hold_q[DATA_W-1], hold_q};

                always @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                    begin
                        hold_q <= {DATA_W{1'b0}};
                        o_q    <= {DATA_W{1'b0}};
                        ph_q   <= 1'b0;
                        ov_q   <= 1'b0;
                    end
                    else if (!mask[s])
                    begin
                        ph_q <= 1'b0;
                        ov_q <= 1'b0;
                    end
                    else
                    begin
                        ov_q <= vv[s] & ph_q;                           // [RULE18]
                        if (vv[s])
                        begin
                            ph_q <= ~ph_q;
                            if (ph_q)
                                o_q <= sum[DATA_W:1];
                            else
                                hold_q <= dd[s];
                        end
                    end
                end

                assign dd[s+1] = mask[s] ? o_q : dd[s];
                assign vv[s+1] = mask[s] ? ov_q : vv[s];                // [RULE11]
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_a       <= {DATA_W{1'b0}};
            out_b       <= {DATA_W{1'b0}};
            out_a_valid <= 1'b0;
            out_b_valid <= 1'b0;
        end
        else
        begin
            out_a_valid <= g_ch[0].vv[NSTAGE];
            out_b_valid <= g_ch[1].vv[NSTAGE];                          // [RULE12]
            if (g_ch[0].vv[NSTAGE])
                out_a <= g_ch[0].dd[NSTAGE];
            if (g_ch[1].vv[NSTAGE])
                out_b <= g_ch[1].dd[NSTAGE];
        end
    end

endmodule

// >>> dv/adc_core_model.sv
`timescale 1ns/1ps

module adc_core_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Pacing from the bench
    input  wire logic        run,
    input  wire logic        slow,
    // Converter samples
    output logic      [15:0] sample_a,
    output logic      [15:0] sample_b,
    output logic             sample_valid,
    output logic             overload
);
    logic [15:0] lfsr_q;
    logic        ph_q;

    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // Samples keep moving while invalid, so a stale capture shows up
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            lfsr_q <= 16'h004e;
            ph_q <= 1'b0;
            sample_valid <= 1'b0;
            overload <= 1'b0;
            sample_a <= 16'h0000;
            sample_b <= 16'h0000;
        end
        else
        begin
            lfsr_q <= nxt(lfsr_q);
            ph_q <= ~ph_q;
            sample_valid <= run && (!slow || ph_q);
            // Half scale at most, so the requantizer loop stays stable
            sample_a <= {lfsr_q[15], lfsr_q[15:1]};
            sample_b <= {lfsr_q[3], lfsr_q[3], lfsr_q[13:0]};
            overload <= run && lfsr_q[4:0] == 5'h1f;
        end
endmodule

// >>> dv/nsr_decim_sva.sv
`timescale 1ns/1ps
`include "nsr_decim_defs.vh"

module nsr_decim_sva #(
    parameter DATA_W = 16
) (
    // Clock and reset
    input wire              pclk,
    input wire              presetn,
    // APB
    input wire [11:0]       paddr,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [31:0]       pwdata,
    input wire [31:0]       prdata,
    input wire              pready,
    input wire              pslverr,
    // Data path
    input wire [1:0]        chan_mode,
    input wire [DATA_W-1:0] sample_a,
    input wire [DATA_W-1:0] sample_b,
    input wire              sample_valid,
    input wire              overload,
    input wire [DATA_W-1:0] out_a,
    input wire              out_a_valid,
    input wire [DATA_W-1:0] out_b,
    input wire              out_b_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire mapped = paddr == `ADDR_REQ_A_TUNE || paddr == `ADDR_REQ_B_TUNE ||
        paddr == `ADDR_REQ_EN_DEC_A_LO || paddr == `ADDR_DEC_A_HI || paddr == `ADDR_DEC_B;

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence

    setup_access_a: assert property (setup_s |=> access_s)
        else $error("setup not followed by access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("mapped access refused");
    b_single_off_a: assert property (chan_mode == `MODE_SINGLE |-> !out_b_valid)
        else $error("channel b output in single mode");
    dual_lockstep_a: assert property (chan_mode == `MODE_DUAL |->
        out_a_valid == out_b_valid) else $error("dual chains out of step");
    bypass_mode_a: assert property (chan_mode == 2'b11 && sample_valid |=>
        out_a_valid && out_a == $past(sample_a)) else $error("other mode not passed through");
    a_hold_a: assert property ($changed(out_a) |-> out_a_valid)
        else $error("out_a moved without valid");
    b_hold_a: assert property ($changed(out_b) |-> out_b_valid)
        else $error("out_b moved without valid");
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
`include "nsr_decim_defs.vh"

module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [1:0]  chan_mode = 2'b00;
    logic        run = 1'b0;
    logic        slow = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, sample_valid, overload, out_a_valid, out_b_valid;
    wire  [15:0] sample_a, sample_b, out_a, out_b;
    integer      bad_count = 0, checked = 0, na = 0, ben = 0, rq = 0, i;
    integer      hold [0:1][0:8];
    bit          have [0:1][0:8];
    integer      qa[$], qb[$];
    logic [6:0]  tw [0:7] = '{7'h00, 7'h14, 7'h15, 7'h29, 7'h2a, 7'h3e, 7'h3f, 7'h4c};

    always #5 pclk = ~pclk;

    nsr_decim nsr_decim_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_mode(chan_mode), .sample_a(sample_a), .sample_b(sample_b),
        .sample_valid(sample_valid), .overload(overload), .out_a(out_a),
        .out_a_valid(out_a_valid), .out_b(out_b), .out_b_valid(out_b_valid));
    adc_core_model adc_core_model_i (.pclk(pclk), .presetn(presetn), .run(run), .slow(slow),
        .sample_a(sample_a), .sample_b(sample_b), .sample_valid(sample_valid),
        .overload(overload));

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task end_of_test;
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task apb(input logic [11:0] a, input logic w, input logic [7:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Wait as long as the slave asks; only the watchdog ends a hang
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("apb error", {31'h0, a < `ADDR_REQ_A_TUNE || a > `ADDR_DEC_B}, {31'h0, e});
    endtask

    // Cascade of halving stages; a partial pair never reaches the queue
    task automatic step(input integer ch, input integer v);
        integer k;
        bit done;
        done = 0;
        for (k = 0; k < na && !done; k++)
            if (have[ch][k])
            begin
                v = (hold[ch][k] + v) >>> 1;
                have[ch][k] = 0;
            end
            else
            begin
                hold[ch][k] = v;
                have[ch][k] = 1;
                done = 1;
            end
        if (!done && ch == 0)
            qa.push_back(v);
        if (!done && ch == 1)
            qb.push_back(v);
    endtask

    task automatic take(input integer ch, input logic [15:0] got);
        integer v;
        if ((ch == 0 ? qa.size() : qb.size()) == 0)
            check("spare output", 32'h0, 32'h1);
        else
        begin
            v = ch == 0 ? qa.pop_front() : qb.pop_front();
            if (rq == 0)
                check("sample", {16'h0, v[15:0]}, {16'h0, got});
            else
                check("low bits", 32'h0, got & ((16'h1 << (16 - rq)) - 16'h1));
        end
    endtask

    always @(posedge pclk)
        if (presetn === 1'b1)
        begin
            if (sample_valid === 1'b1)
                step(0, $signed(sample_a));
            if (sample_valid === 1'b1 && ben != 0)
                step(1, $signed(sample_b));
            if (out_a_valid === 1'b1)
                take(0, out_a);
            if (out_b_valid === 1'b1)
                take(1, out_b);
        end

    // Configuration bytes in c run from the requant_a_tuning_cfg register upwards
    task scen(input logic [1:0] mode, input logic [39:0] c, input integer a_st, b_en, req, ns,
              input logic sl);
        integer j;
        logic [31:0] r;
        logic e;
        presetn <= 1'b0;
        chan_mode <= mode;
        slow <= sl;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        have = '{default: 0};
        qa.delete();
        qb.delete();
        na = a_st;
        ben = b_en;
        rq = req;
        for (j = 0; j < 5; j++)
        begin
            apb(`ADDR_REQ_A_TUNE + 12'(j * 4), 1'b0, 8'h00, r, e);
            check("reset value", {24'h0, `CFG_RESET}, r);
            apb(`ADDR_REQ_A_TUNE + 12'(j * 4), 1'b1, c[j*8+:8], r, e);
            apb(`ADDR_REQ_A_TUNE + 12'(j * 4), 1'b0, 8'h00, r, e);
            check("readback", {24'h0, c[j*8+:8]}, r);
        end
        apb(12'h1f4, 1'b0, 8'h00, r, e);
        check("unmapped error", 32'h1, {31'h0, e});
        run <= 1'b1;
        repeat (ns * (sl + 1)) @(posedge pclk);
        run <= 1'b0;
        repeat (40) @(posedge pclk);
        check("a left over", 32'h0, 32'(qa.size()));
        check("b left over", 32'h0, 32'(qb.size()));
    endtask

    initial
    begin
        // The first scenario adds two more reset cycles, sixteen in all
        repeat (14) @(posedge pclk);
        scen(2'b00, 40'h0, 0, 0, 0, 40, 1'b0);
        scen(2'b00, {8'h00, 8'h03, 8'h01, 16'h0}, 3, 0, 0, 64, 1'b1);
        scen(2'b00, {8'h00, 8'hff, 8'h01, 16'h0}, 9, 0, 0, 1024, 1'b0);
        scen(2'b01, {8'h06, 8'h06, 8'h00, 8'h80, 8'h00}, 2, 1, 0, 64, 1'b1);
        scen(2'b01, {8'hff, 8'hff, 8'h00, 8'h80, 8'h00}, 8, 1, 0, 512, 1'b0);
        scen(2'b01, {8'hff, 8'hff, 8'h00, 16'h0}, 0, 1, 0, 32, 1'b0);
        scen(2'b01, {8'h00, 8'h00, 8'h50, 8'h80, 8'h00}, 0, 1, 11, 48, 1'b0);
        scen(2'b10, {8'hff, 8'h01, 8'h01, 16'h0}, 2, 0, 0, 32, 1'b0);
        scen(2'b11, {8'hff, 8'hff, 8'h01, 16'h0}, 0, 0, 0, 32, 1'b0);
        for (i = 0; i < 8; i++)
            scen(2'b00, {16'h0, (i < 4) ? 8'h10 : 8'h20, 8'h00, 1'b1, tw[i]}, 0, 0,
                 (i < 4) ? 11 : 12, 48, 1'b0);
        end_of_test;
    end

    initial
    begin
        #100000;
        bad_count++;
        end_of_test;
    end
endmodule

bind nsr_decim nsr_decim_sva #(.DATA_W(DATA_W)) sva_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_mode(chan_mode),
    .sample_a(sample_a), .sample_b(sample_b), .sample_valid(sample_valid),
    .overload(overload), .out_a(out_a), .out_a_valid(out_a_valid), .out_b(out_b),
    .out_b_valid(out_b_valid));
